// ### hdl/rcs_top.sv
`timescale 1ns/1ps
module rcs_top #(
   parameter logic [16:0] POR_DELAY_CYCLES = 17'(rcs_pkg::POR_DELAY_CYC)
) (
   input  wire  logic                i_clk,
   input  wire  logic                i_rst_n,          // power-on reset
   input  wire  logic                i_ce,
   // non-volatile array and programmer side
   input  wire  logic [11:0]         i_nv_config,
   input  wire  logic                i_prog_en,
   input  wire  logic                i_prog_we,
   input  wire  logic [11:0]         i_prog_wdata,
   input  wire  logic [7:0]          i_prog_mem_addr,
   output logic [11:0]               o_prog_rdata,
   output logic                      o_nv_wr,
   output logic [11:0]               o_nv_wdata,
   output logic                      o_prog_mem_read_ok,
   // pins and events
   input  wire  logic                i_master_clear_pin_pin_n,
   input  wire  logic                i_wdt_timeout,
   input  wire  logic                i_pin_change,
   input  wire  logic                i_sleep,
   input  wire  logic [7:0]          i_cal_word,
   // cpu register side
   input  wire  logic [4:0]          i_reg_addr,
   input  wire  logic                i_reg_we,
   input  wire  logic [7:0]          i_reg_wdata,
   output logic [7:0]                o_reg_rdata,
   // reset and static controls
   output logic                      o_cpu_reset,
   output logic                      o_regs_reset,
   output logic                      o_wake,
   output logic [7:0]                o_pc_low,
   output logic                      o_w_load,
   output logic [7:0]                o_w_value,
   output rcs_pkg::rcs_cfg_type      o_cfg,
   output logic                      o_pin_is_gpio,
   output logic                      o_pullup_on,
   output logic [7:0]                o_osc_trim,
   output logic [7:0]                o_conv_ctrl
);
   import rcs_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   rcs_cfg_type        cfg_reg,    cfg_next;     // latched configuration
   rcs_state_type      state_reg,  state_next;   // sequencer state
   logic [DLY_W-1:0]   dly_reg,    dly_next;     // startup delay countdown
   logic [7:0]         status_reg, status_next;  // cpu_status_flags
   logic [7:0]         trim_reg,   trim_next;    // oscillator_trim
   logic [7:0]         conv_reg,   conv_next;    // converter_control_reg
   logic [7:0]         pc_reg,     pc_next;      // program counter low byte
   logic               wld_reg,    wld_next;     // calibration load pulse
   logic [7:0]         wval_reg,   wval_next;    // literal loaded into W
   logic               rr_reg,     rr_next;      // ordinary register reset
   logic               wake_reg,   wake_next;    // wake pulse
   logic               nvw_reg,    nvw_next;     // array write strobe
   logic [11:0]        nvd_reg,    nvd_next;     // array write data
   logic [7:0]         rd_reg,     rd_next;      // cpu read data

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic master_clear_pin_s1_reg, master_clear_pin_s2_reg;  // master-clear pin, low active
   logic wdt_s1_reg,  wdt_s2_reg;   // watchdog runs on its own oscillator
   logic wdt_d_reg;                 // previous synced level for edge

   // two flops each, plus an edge flop on the watchdog; the second stage and that edge flop feed logic
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         // keep sampling the pin so a clear held through power-up is seen at release
         master_clear_pin_s1_reg <= i_master_clear_pin_pin_n;
         master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
         wdt_s1_reg  <= 1'b0;
         wdt_s2_reg  <= 1'b0;
         wdt_d_reg   <= 1'b0;
      end else if (i_ce) begin
         master_clear_pin_s1_reg <= i_master_clear_pin_pin_n;
         master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
         wdt_s1_reg  <= i_wdt_timeout;
         wdt_s2_reg  <= wdt_s1_reg;
         wdt_d_reg   <= wdt_s2_reg;
      end
   end

   // ---------------------------------------------------------------
   // event decode
   // ---------------------------------------------------------------
   logic         master_clear_pin_act;  // pin holds the device in reset
   logic         wdt_evt;   // one cycle per time-out
   logic         ev_any;    // any reset source this cycle
   rcs_kind_type kind;      // highest-priority source

   // in digital mode the clear function is tied inactive
   assign master_clear_pin_act = cfg_reg.pin_function_select & ~master_clear_pin_s2_reg;  // [R2] [R21]
   // only the config bit can stop the watchdog
   assign wdt_evt  = cfg_reg.watchdog_enable_bit & wdt_s2_reg & ~wdt_d_reg;  // [R4]

   // power-up is handled by the reset branch, so it always wins
   always_comb begin
      kind = KIND_NONE;
      if (master_clear_pin_act) begin  // [R24]
         kind = i_sleep ? KIND_MASTER_CLEAR_PIN_SLEEP : KIND_MASTER_CLEAR_PIN_RUN;
      end else if (wdt_evt) begin
         kind = i_sleep ? KIND_WDT_SLEEP : KIND_WDT_RUN;
      end else if (i_pin_change && i_sleep) begin  // [R9]
         kind = KIND_PIN_WAKE;
      end
   end

   // a held master-clear is seen as one event on entry only; while power-up
   // still waits for the pin, nothing may cut the long delay short [R22]
   assign ev_any = (kind != KIND_NONE) && (state_reg != ST_WAIT_PIN) &&
                   !(master_clear_pin_act && state_reg == ST_DELAY);

   // ---------------------------------------------------------------
   // status flag patterns per reset kind
   // ---------------------------------------------------------------
   function automatic logic [7:0] rcs_status_load(input rcs_kind_type k,
                                                  input logic [7:0] s);
      logic [7:0] r;
      r = s;
      unique case (k)  // [R20]
         KIND_MASTER_CLEAR_PIN_RUN: begin  // [R15]
            r[ST_PIN_WAKE] = 1'b0;
         end
         KIND_MASTER_CLEAR_PIN_SLEEP: begin  // [R15]
            r[ST_PIN_WAKE]  = 1'b0;
            r[ST_TIME_EXP]  = 1'b1;
            r[ST_POWERDOWN] = 1'b0;
         end
         KIND_WDT_SLEEP: begin  // [R16]
            r[ST_PIN_WAKE]  = 1'b0;
            r[ST_TIME_EXP]  = 1'b0;
            r[ST_POWERDOWN] = 1'b0;
         end
         KIND_WDT_RUN: begin  // [R16]
            r[ST_PIN_WAKE]  = 1'b0;
            r[ST_TIME_EXP]  = 1'b0;
         end
         KIND_PIN_WAKE: begin  // [R16]
            r[ST_PIN_WAKE]  = 1'b1;
            r[ST_TIME_EXP]  = 1'b1;
            r[ST_POWERDOWN] = 1'b0;
         end
         KIND_NONE: begin
            r = s;
         end
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // sequencer and register file, next values
   // ---------------------------------------------------------------
   // master-clear and watchdog sleep resets are a resumption, so ordinary registers stay put; pin wake resets them
   logic ordinary;
   assign ordinary = (kind == KIND_MASTER_CLEAR_PIN_RUN) || (kind == KIND_WDT_RUN) ||
                     (kind == KIND_PIN_WAKE);  // [R13]

   always_comb begin
      cfg_next    = cfg_reg;      // fixed after power-up [R23]
      state_next  = state_reg;
      dly_next    = dly_reg;
      status_next = status_reg;
      trim_next   = trim_reg;     // survives non-power resets [R18]
      conv_next   = conv_reg;
      pc_next     = pc_reg;
      wld_next    = 1'b0;
      wval_next   = wval_reg;
      rr_next     = 1'b0;
      wake_next   = 1'b0;
      nvw_next    = 1'b0;
      nvd_next    = nvd_reg;
      rd_next     = 8'h00;        // unmapped reads return zero

      // programmer is the only path to the stored word [R7]
      if (i_prog_en && i_prog_we) begin
         nvw_next = 1'b1;
         nvd_next = i_prog_wdata & CFG_IMPL_MASK;  // [R1]
      end

      // software access while running
      if (state_reg == ST_RUN && i_reg_we) begin
         unique case (i_reg_addr)
            ADDR_STATUS: begin
               status_next = (i_reg_wdata & STATUS_SW_MASK) |
                             (status_reg & ~STATUS_SW_MASK);
            end
            ADDR_TRIM: begin
               trim_next = i_reg_wdata;  // [R12]
            end
            ADDR_CONV: begin
               conv_next = i_reg_wdata & CONV_MASK;
            end
            default: begin
               conv_next = conv_reg;
            end
         endcase
      end
      unique case (i_reg_addr)
         ADDR_STATUS: rd_next = status_reg;
         ADDR_TRIM:   rd_next = trim_reg;
         ADDR_CONV:   rd_next = conv_reg;
         default:     rd_next = 8'h00;
      endcase

      unique case (state_reg)
         // power-up: delay starts only once the pin is released
         ST_WAIT_PIN: begin
            if (!master_clear_pin_act) begin  // [R22]
               state_next = ST_DELAY;
            end
         end
         // countdown, restarted while the pin is still held
         ST_DELAY: begin
            if (master_clear_pin_act) begin
               dly_next = DLY_W'(SUB_DELAY_CYC);
            end else if (dly_reg <= DLY_W'(1)) begin
               state_next = ST_RUN;
               wld_next   = 1'b1;
               wval_next  = i_cal_word;  // literal sets W<7:0> [R19]
            end else begin
               dly_next = dly_reg - DLY_W'(1);
            end
         end
         ST_RUN: begin
            // first fetch after the literal wraps to zero
            if (wld_reg) begin
               pc_next = PC_WRAP;  // [R11]
            end
         end
         default: begin
            state_next = ST_WAIT_PIN;
         end
      endcase

      // a reset event beats status and converter writes in the same cycle; a trim write still lands
      if (ev_any) begin
         state_next  = ST_DELAY;
         dly_next    = DLY_W'(SUB_DELAY_CYC);  // short delay for every later reset [R8] [R22]
         pc_next     = PC_RESET;               // [R17] [R11]
         conv_next   = CONV_RESET;             // every reset [R18]
         status_next = rcs_status_load(kind, status_reg);
         rr_next     = ordinary;               // [R13]
         wake_next   = (kind == KIND_PIN_WAKE) || (kind == KIND_WDT_SLEEP) ||
                       (kind == KIND_MASTER_CLEAR_PIN_SLEEP);  // [R9]
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // indirect, timer and result data live elsewhere and are not touched here [R14]
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cfg_reg    <= rcs_cfg_type'(i_nv_config[4:0]);   // [R23]
         state_reg  <= ST_WAIT_PIN;
         dly_reg    <= POR_DELAY_CYCLES;                   // [R8] [R22]
         status_reg <= STATUS_POR_LOW | 8'h18;             // 01 1xxx [R15]
         trim_reg   <= TRIM_RESET;                         // [R18]
         conv_reg   <= CONV_RESET;                         // [R18]
         pc_reg     <= PC_RESET;                           // [R17]
         wld_reg    <= 1'b0;
         wval_reg   <= 8'h00;
         rr_reg     <= 1'b1;                               // [R13]
         wake_reg   <= 1'b0;
         nvw_reg    <= 1'b0;
         nvd_reg    <= 12'h000;
         rd_reg     <= 8'h00;
      end else if (i_ce) begin
         cfg_reg    <= cfg_next;
         state_reg  <= state_next;
         dly_reg    <= dly_next;
         status_reg <= status_next;
         trim_reg   <= trim_next;
         conv_reg   <= conv_next;
         pc_reg     <= pc_next;
         wld_reg    <= wld_next;
         wval_reg   <= wval_next;
         rr_reg     <= rr_next;
         wake_reg   <= wake_next;
         nvw_reg    <= nvw_next;
         nvd_reg    <= nvd_next;
         rd_reg     <= rd_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // read-back shows the latched word; upper bits always zero
   assign o_prog_rdata       = {7'h00, cfg_reg} & CFG_IMPL_MASK;  // [R1] [R7]
   assign o_nv_wr            = nvw_reg;
   assign o_nv_wdata         = nvd_reg;
   // calibration word stays readable even when protected
   assign o_prog_mem_read_ok = cfg_reg.protect_bit ||
                               (i_prog_mem_addr == CAL_ADDR);  // [R3] [R10]
   assign o_reg_rdata        = rd_reg;
   assign o_cpu_reset        = (state_reg != ST_RUN);  // held while the timer runs [R22]
   assign o_regs_reset       = rr_reg;
   assign o_wake             = wake_reg;
   assign o_pc_low           = pc_reg;
   assign o_w_load           = wld_reg;
   assign o_w_value          = wval_reg;
   assign o_cfg              = cfg_reg;
   assign o_pin_is_gpio      = ~cfg_reg.pin_function_select;  // [R2]
   // pull-up choice counts only in master-clear mode
   assign o_pullup_on        = cfg_reg.pin_function_select &
                               ~cfg_reg.clear_pin_pullup_enable;  // [R5]
   assign o_osc_trim         = trim_reg;  // [R12] [R6] frequency via o_cfg
   assign o_conv_ctrl        = conv_reg;

endmodule

// ### hdl/rcs_pkg.sv
// Summary of operation
// [R1] 12-bit config word, bits 11-5 read zero
// [R2] bit 4 selects master-clear or digital pin
// [R3] bit 3 low turns code protection on
// [R4] bit 2 alone enables the watchdog
// [R5] bit 1 low enables pull-up, master-clear only
// [R6] bit 0 high selects the fast clock
// [R7] config reachable only from the programmer
// [R8] long startup delay only on power-up
// [R9] sleep wakes on pin change or watchdog
// [R10] top calibration location always readable
// [R11] reset starts at top, then wraps to zero
// [R12] trim register write adjusts the oscillator
// [R13] ordinary registers reset, except sleep resets; code also resets them on pin wake
// [R14] some registers keep content through resets
// [R15] status patterns for power-up and master-clear
// [R16] status patterns for watchdog and pin wake
// [R17] program counter low byte set to ones
// [R18] trim resets on power-up, converter always
// [R19] W holds calibration bits after reset
// [R20] flags tell software which reset occurred
// [R21] digital pin mode ties master-clear inactive
// [R22] delay timer long after power-up, short otherwise
// [R23] config latched once during power-up
// [R24] power-up wins over every other source
package rcs_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;         // 100 MHz system clock
   localparam int unsigned POR_DELAY_NS   = 1_125_000;  // 1.125 ms after power-up
   localparam int unsigned SUB_DELAY_NS   = 10_000;     // 10 us after later resets
   localparam int unsigned DLY_W          = 17;         // counter wide enough for power-up
   localparam int unsigned POR_DELAY_CYC  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SUB_DELAY_CYC  = (SUB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // register map and field positions
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_STATUS     = 5'h03;  // cpu_status_flags
   localparam logic [4:0] ADDR_TRIM       = 5'h05;  // oscillator_trim
   localparam logic [4:0] ADDR_CONV       = 5'h07;  // converter_control_reg
   localparam int unsigned ST_PIN_WAKE    = 7;      // pin_wake_flag position
   localparam int unsigned ST_TIME_EXP    = 4;      // time_expiry_flag position
   localparam int unsigned ST_POWERDOWN   = 3;      // powerdown_flag position
   localparam logic [7:0] TRIM_RESET      = 8'hFE;
   localparam logic [7:0] CONV_RESET      = 8'hCC;  // bits 5-4 unimplemented
   localparam logic [7:0] CONV_MASK       = 8'hCF;
   localparam logic [7:0] STATUS_POR_LOW  = 8'h00;  // unknown bits chosen as zero
   localparam logic [7:0] STATUS_SW_MASK  = 8'hE7;  // flags 4 and 3 read-only
   localparam logic [7:0] PC_RESET        = 8'hFF;
   localparam logic [7:0] PC_WRAP         = 8'h00;
   localparam logic [7:0] CAL_ADDR        = 8'hFF;  // top of program memory
   localparam logic [11:0] CFG_IMPL_MASK  = 12'h01F;
   localparam int unsigned CFG_PINFN      = 4;
   localparam int unsigned CFG_PROTECT    = 3;
   localparam int unsigned CFG_WDOG       = 2;
   localparam int unsigned CFG_PULLUP     = 1;
   localparam int unsigned CFG_FREQ       = 0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic pin_function_select;      // 1 = master-clear pin
      logic protect_bit;              // 0 = code protected
      logic watchdog_enable_bit;      // 1 = watchdog running
      logic clear_pin_pullup_enable;  // 0 = pull-up on
      logic osc_freq_select;          // 1 = fast clock
   } rcs_cfg_type;

   typedef enum logic [2:0] {
      KIND_NONE,
      KIND_MASTER_CLEAR_PIN_RUN,
      KIND_MASTER_CLEAR_PIN_SLEEP,
      KIND_WDT_SLEEP,
      KIND_WDT_RUN,
      KIND_PIN_WAKE
   } rcs_kind_type;

   typedef enum logic [2:0] {
      ST_WAIT_PIN = 3'b001,
      ST_DELAY    = 3'b010,
      ST_RUN      = 3'b100
   } rcs_state_type;

endpackage

// ### verification/rcs_top_props.sv
`timescale 1ns/1ps
module rcs_top_props #(
   parameter logic [16:0] POR_DELAY_CYCLES = 17'h00014
) (
   input wire logic                 i_clk,
   input wire logic                 i_rst_n,
   input wire logic                 i_prog_en,
   input wire logic                 i_prog_we,
   input wire logic [11:0]          i_prog_wdata,
   input wire logic [7:0]           i_prog_mem_addr,
   input wire logic [11:0]          o_prog_rdata,
   input wire logic                 o_nv_wr,
   input wire logic [11:0]          o_nv_wdata,
   input wire logic                 o_prog_mem_read_ok,
   input wire logic [7:0]           i_cal_word,
   input wire logic                 o_cpu_reset,
   input wire logic [7:0]           o_pc_low,
   input wire logic                 o_w_load,
   input wire logic [7:0]           o_w_value,
   input wire rcs_pkg::rcs_cfg_type o_cfg,
   input wire logic                 o_pin_is_gpio,
   input wire logic                 o_pullup_on
);
   import rcs_pkg::*;
   // ------------------------------------------------------------
   // reset length tracker
   // ------------------------------------------------------------
   logic [10:0] hi_reg, hi_next;       // cycles held in reset, saturating
   logic        first_reg, first_next; // power-up release still pending
   // saturate so a long held pin cannot wrap the count
   always_comb begin
      first_next = (first_reg && o_cpu_reset) || !i_rst_n;
      hi_next    = hi_reg + {10'h000, hi_reg != 11'h7FF};
      if (!o_cpu_reset || !i_rst_n) begin
         hi_next = 11'h000;
      end
   end
   always_ff @(posedge i_clk) begin
      hi_reg    <= hi_next;
      first_reg <= first_next;
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   upper_zero_a: assert property (o_prog_rdata[11:5] == 7'h00)
      else $error("config upper bits not zero");
   gpio_select_a: assert property (o_pin_is_gpio == !o_cfg.pin_function_select)
      else $error("pin function decode wrong");
   pullup_only_a: assert property (
      o_pullup_on == (o_cfg.pin_function_select && !o_cfg.clear_pin_pullup_enable))
      else $error("pull-up decode wrong");
   read_gate_a: assert property (
      o_prog_mem_read_ok == (o_cfg.protect_bit || i_prog_mem_addr == 8'hFF))
      else $error("program read gate wrong");
   cfg_frozen_a: assert property ($past(i_rst_n) |-> $stable(o_cfg))
      else $error("config changed outside power-up");
   nv_write_a: assert property (
      i_prog_en && i_prog_we |=> o_nv_wr && o_nv_wdata == ($past(i_prog_wdata) & 12'h01F))
      else $error("programmer write not forwarded");
   pc_top_a: assert property ($rose(o_cpu_reset) |-> o_pc_low == 8'hFF)
      else $error("program counter not at top on reset");
   cal_load_a: assert property (
      $fell(o_cpu_reset) |-> o_w_load && o_w_value == $past(i_cal_word))
      else $error("calibration not loaded at reset exit");
   pc_wrap_a: assert property (o_w_load |=> o_pc_low == 8'h00)
      else $error("program counter did not wrap");
   short_por_a: assert property (
      $fell(o_cpu_reset) && first_reg |-> {6'h00, hi_reg} <= POR_DELAY_CYCLES + 17'h0000A)
      else $error("power-up delay too long");
   long_sub_a: assert property ($fell(o_cpu_reset) && !first_reg |-> hi_reg >= 11'h3DE)
      else $error("later reset delay too short");
   cover property ($fell(o_cpu_reset) && !first_reg);
   cover property (o_w_load);
   cover property (o_nv_wr);
endmodule
bind rcs_top rcs_top_props #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) u_props (
   .i_clk, .i_rst_n, .i_prog_en, .i_prog_we, .i_prog_wdata, .i_prog_mem_addr,
   .o_prog_rdata, .o_nv_wr, .o_nv_wdata, .o_prog_mem_read_ok, .i_cal_word, .o_cpu_reset,
   .o_pc_low, .o_w_load, .o_w_value, .o_cfg, .o_pin_is_gpio, .o_pullup_on
);

// ### verification/rcs_pin_prog_model.sv
`timescale 1ns/1ps
module rcs_pin_prog_model (
   input  wire logic   i_clk,
   output logic        o_master_clear_pin_pin_n,
   output logic        o_prog_en,
   output logic        o_prog_we,
   output logic [11:0] o_prog_wdata
);
   // idle: pin pulled high, programmer quiet
   initial begin
      o_master_clear_pin_pin_n = 1'b1;
      o_prog_en    = 1'b0;
      o_prog_we    = 1'b0;
      o_prog_wdata = 12'hFFF;
   end
   // pin low for n cycles, then the pull-up brings it back
   task automatic clear_pulse(input int n);
      @(posedge i_clk);
      o_master_clear_pin_pin_n <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_master_clear_pin_pin_n <= 1'b1;
   endtask
   // one write; data inverted after so no stale copy lingers
   task automatic program_word(input logic [11:0] d);
      @(posedge i_clk);
      o_prog_en    <= 1'b1;
      o_prog_we    <= 1'b1;
      o_prog_wdata <= d;
      @(posedge i_clk);
      o_prog_en    <= 1'b0;
      o_prog_we    <= 1'b0;
      o_prog_wdata <= ~d;
   endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rcs_pkg::*;
   localparam logic [16:0] POR_CYC  = 17'h00014; // shortened power-up delay
   localparam logic [7:0]  CAL_WORD = 8'hB4;     // calibration literal
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] nv_cfg = 12'hFFF;
   logic        wdt = 1'b0, pchg = 1'b0, slp = 1'b0, we = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic [7:0]  wdata = 8'h00, pma = 8'h00;
   logic        master_clear_pin_n, p_en, p_we;
   logic [11:0] p_wdata;
   int          n_fail = 0, num_checks = 0, n_wake = 0, n_rr = 0, cyc;
   rcs_pin_prog_model pin (.i_clk(clk), .o_master_clear_pin_pin_n(master_clear_pin_n), .o_prog_en(p_en),
      .o_prog_we(p_we), .o_prog_wdata(p_wdata));
   rcs_top #(.POR_DELAY_CYCLES(POR_CYC)) dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_nv_config(nv_cfg), .i_prog_en(p_en),
      .i_prog_we(p_we), .i_prog_wdata(p_wdata), .i_prog_mem_addr(pma), .o_prog_rdata(),
      .o_nv_wr(), .o_nv_wdata(), .o_prog_mem_read_ok(), .i_master_clear_pin_pin_n(master_clear_pin_n),
      .i_wdt_timeout(wdt), .i_pin_change(pchg), .i_sleep(slp), .i_cal_word(CAL_WORD),
      .i_reg_addr(addr), .i_reg_we(we), .i_reg_wdata(wdata), .o_reg_rdata(), .o_cpu_reset(),
      .o_regs_reset(), .o_wake(), .o_pc_low(), .o_w_load(), .o_w_value(), .o_cfg(),
      .o_pin_is_gpio(), .o_pullup_on(), .o_osc_trim(), .o_conv_ctrl());
   always #5 clk = ~clk;
   // wake pulses counted on the quiet edge
   always @(negedge clk) if (dut.o_wake === 1'b1) n_wake++;
   // ordinary register reset pulses, same quiet edge
   always @(negedge clk) if (dut.o_regs_reset === 1'b1) n_rr++;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic por(input logic [11:0] c);
      @(posedge clk);
      rst_n  <= 1'b0;
      nv_cfg <= c;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      we    <= 1'b1;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic reg_rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 check({4'h0, dut.o_reg_rdata}, {4'h0, e});
   endtask
   // bounded wait for the end of the reset delay
   task automatic wait_run(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (dut.o_w_load !== 1'b1 && n < 1500);
      check(12'(dut.o_w_load), 12'h001);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_power_up();
      // pin held low across the release: delay must still be the long one
      fork
         por(12'hFFF);
         pin.clear_pulse(6);
      join
      check(dut.o_prog_rdata, 12'h01F);
      check(12'(dut.o_pin_is_gpio), 12'h000);
      check(12'(dut.o_pullup_on), 12'h000);
      check(12'(dut.o_cfg), 12'h01F);
      wait_run(cyc);
      check(12'(cyc inside {[20:32]}), 12'h001);
      check(12'(dut.o_w_value), 12'(CAL_WORD));
      @(posedge clk);
      #1 check(12'(dut.o_pc_low), 12'h000);
      reg_rd(ADDR_STATUS, 8'h18);
      reg_rd(ADDR_TRIM, TRIM_RESET);
   endtask
   task automatic t_regs();
      reg_wr(ADDR_TRIM, 8'hAA);
      #1 check(12'(dut.o_osc_trim), 12'h0AA);
      reg_wr(ADDR_STATUS, 8'h00);
      reg_rd(ADDR_STATUS, 8'h18);
      reg_wr(5'h1F, 8'h55);
      reg_rd(5'h1F, 8'h00);
   endtask
   // wdt run, clear in sleep, wdt in sleep, pin wake, clear run
   task automatic t_reset_kinds();
      logic [7:0] st [5] = '{8'h08, 8'h10, 8'h00, 8'h90, 8'h10};
      for (int k = 0; k < 5; k++) begin
         int w0, r0;
         reg_wr(ADDR_CONV, 8'hFF);
         w0 = n_wake;
         r0 = n_rr;
         @(posedge clk);
         slp <= k inside {[1:3]};
         if (k == 0 || k == 2) begin
            wdt <= 1'b1;
            @(posedge clk);
            wdt <= 1'b0;
            // sleep stays up until the synchronised edge reaches the decoder
            repeat (2) @(posedge clk);
         end else if (k == 3) begin
            pchg <= 1'b1;
            @(posedge clk);
            pchg <= 1'b0;
         end else begin
            pin.clear_pulse(4);
         end
         slp <= 1'b0;
         wait_run(cyc);
         check(12'(cyc >= 990), 12'h001);
         check(12'(n_wake - w0), 12'(k inside {[1:3]}));
         check(12'(n_rr - r0), 12'(k inside {0, 3, 4}));
         reg_rd(ADDR_STATUS, st[k]);
         reg_rd(ADDR_TRIM, 8'hAA);
         reg_rd(ADDR_CONV, CONV_RESET);
      end
   endtask
   task automatic t_prog();
      pin.program_word(12'hABC);
      #1 check(12'(dut.o_nv_wr), 12'h001);
      check(dut.o_nv_wdata, 12'h01C);
      check(dut.o_prog_rdata, 12'h01F);
   endtask
   task automatic t_gpio();
      por(12'h000);
      check(12'(dut.o_pin_is_gpio), 12'h001);
      check(12'(dut.o_pullup_on), 12'h000);
      check(12'(dut.o_cfg.osc_freq_select), 12'h000);
      wait_run(cyc);
      @(posedge clk);
      pma <= 8'h10;
      #1 check(12'(dut.o_prog_mem_read_ok), 12'h000);
      @(posedge clk);
      pma <= 8'hFF;
      #1 check(12'(dut.o_prog_mem_read_ok), 12'h001);
      pin.clear_pulse(4);
      #1 check(12'(dut.o_cpu_reset), 12'h000);
      @(posedge clk);
      wdt <= 1'b1;
      repeat (6) @(posedge clk);
      wdt <= 1'b0;
      #1 check(12'(dut.o_cpu_reset), 12'h000);
   endtask
   initial begin
      t_power_up();
      t_regs();
      t_reset_kinds();
      t_prog();
      t_gpio();
      summarize();
   end
   // hang guard, several times the expected run
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule
